// ---- hw/notch_cfg_pkg.sv ----
// Constants, codes and types shared by the notch filter clock and configuration logic.
//
// Contract
// - The divider divides the oscillator-side clock by 716, 596 or 2 for divide_factor_sel at positive rail, ground or negative rail.
// - With clock_source_sel at positive rail the oscillator and divider run and the divider output drives the filter clock pin.
// - With clock_source_sel at ground the oscillator and divider stop and the filter clock pin is a CMOS-level clock input.
// - With clock_source_sel at negative rail the oscillator and divider stop and the filter clock pin is a TTL-level clock input.
// - The filter clock to notch centre ratio is 33.33, 50 or 100 for sample_to_notch_pick at positive rail, ground or negative rail.
// - The running divider takes its input from the crystal oscillator or an external CMOS clock on osc_in_pin.
// - The notch width is 0.55, 0.26 or 0.127 of centre for notch_span_sel at positive rail, ground or negative rail.
// - The two-level attenuation_level picks one of two notch depths from negative rail and ground levels.
// - Width, depth and ratio act independently, giving eighteen distinct configurations.
// - The filter input is sampled once per filter clock cycle and the bandpass output changes at most once per cycle.
// - The clock delivered by the divider has a 50% duty cycle.
package notch_cfg_pkg;

   // Two-bit codes of a three-level programming input.
   localparam logic [1:0] LVL_GND     = 2'h0;
   localparam logic [1:0] LVL_POS     = 2'h1;
   localparam logic [1:0] LVL_NEG     = 2'h2;
   localparam logic [1:0] LVL_INVALID = 2'h3;

   // Index of a level when building the configuration number.
   localparam logic [4:0] IDX_POS = 5'h00;
   localparam logic [4:0] IDX_GND = 5'h01;
   localparam logic [4:0] IDX_NEG = 5'h02;
   localparam logic [4:0] WEIGHT_DEPTH = 5'h03;
   localparam logic [4:0] WEIGHT_RATIO = 5'h06;

   // Divider factors and the matching half periods in oscillator edges.
   localparam int         DIV_W        = 10;
   localparam logic [9:0] DIV_POS      = 10'h2CC;
   localparam logic [9:0] DIV_GND      = 10'h254;
   localparam logic [9:0] DIV_NEG      = 10'h002;
   localparam logic [9:0] HALF_POS     = DIV_POS >> 1;
   localparam logic [9:0] HALF_GND     = DIV_GND >> 1;
   localparam logic [9:0] HALF_NEG     = DIV_NEG >> 1;

   // Filter clock to notch centre ratio, in hundredths.
   localparam logic [13:0] RATIO_POS = 14'h0D05;
   localparam logic [13:0] RATIO_GND = 14'h1388;
   localparam logic [13:0] RATIO_NEG = 14'h2710;

   // Notch width relative to centre, in thousandths.
   localparam logic [9:0] WIDTH_POS = 10'h226;
   localparam logic [9:0] WIDTH_GND = 10'h104;
   localparam logic [9:0] WIDTH_NEG = 10'h07F;

   // Notch depth in dB.
   localparam logic [5:0] DEPTH_NEG = 6'h28;
   localparam logic [5:0] DEPTH_GND = 6'h1E;

   // Data path and measurement widths.
   localparam int          SAMPLE_W    = 12;
   localparam int          PERIOD_W    = 16;
   localparam logic [15:0] PERIOD_MAX  = 16'hFFFF;
   localparam logic [15:0] PERIOD_ZERO = 16'h0000;

   // Clock source mode, one-hot.
   typedef enum logic [2:0] {
      SRC_OSC  = 3'b001,
      SRC_CMOS = 3'b010,
      SRC_TTL  = 3'b100
   } clk_src_t;

endpackage : notch_cfg_pkg

// ---- hw/osc_divider.sv ----
// Divider that turns oscillator edges into a square filter clock.
`timescale 1ns/1ps
module osc_divider (
   // Clock and reset.
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   // Control.
   input  wire logic       enable_i,
   input  wire logic       src_rise_i,
   input  wire logic [9:0] half_count_i,
   // Divided clock.
   output logic            div_clk_o
);

   logic [9:0] count_q;
   logic [9:0] count_d;
   logic       div_q;
   logic       div_d;

   // The output toggles every half period of oscillator edges, so high and low last alike.
   always_comb begin
      count_d = count_q;
      div_d   = div_q;
      if (!enable_i) begin
         count_d = 10'h000;
         div_d   = 1'b0;
      end else if (src_rise_i) begin
         if (count_q >= half_count_i - 10'h001) begin
            count_d = 10'h000;
            div_d   = ~div_q;
         end else begin
            count_d = count_q + 10'h001;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         count_q <= 10'h000;
         div_q   <= 1'b0;
      end else begin
         count_q <= count_d;
         div_q   <= div_d;
      end
   end

   assign div_clk_o = div_q;

endmodule : osc_divider

// ---- hw/filter_sampler.sv ----
// Sample stage that takes one input sample per filter clock cycle.
`timescale 1ns/1ps
module filter_sampler (
   // Clock and reset.
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   // Sampling strobe and data.
   input  wire logic        filt_rise_i,
   input  wire logic [11:0] sample_in_i,
   // Results.
   output logic [11:0]      sample_o,
   output logic [11:0]      bandpass_o,
   output logic             strobe_o
);

   logic [11:0] sample_q;
   logic [11:0] sample_d;
   logic [11:0] band_q;
   logic [11:0] band_d;
   logic        strobe_q;
   logic        strobe_d;

   // The held sample moves into the output stage only on a filter clock edge.
   always_comb begin
      sample_d = sample_q;
      band_d   = band_q;
      strobe_d = 1'b0;
      if (filt_rise_i) begin
         sample_d = sample_in_i;
         band_d   = sample_q;
         strobe_d = 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sample_q <= 12'h000;
         band_q   <= 12'h000;
         strobe_q <= 1'b0;
      end else begin
         sample_q <= sample_d;
         band_q   <= band_d;
         strobe_q <= strobe_d;
      end
   end

   assign sample_o   = sample_q;
   assign bandpass_o = band_q;
   assign strobe_o   = strobe_q;

endmodule : filter_sampler

// ---- hw/notch_filter_clock_config.sv ----
// Top of the notch filter clock source, divider and programming logic.
`timescale 1ns/1ps
module notch_filter_clock_config (
   // Clock and reset.
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   // Programming inputs, two-bit three-level codes.
   input  wire logic [1:0]  divide_factor_sel_i,
   input  wire logic [1:0]  clock_source_sel_i,
   input  wire logic [1:0]  sample_to_notch_pick_i,
   input  wire logic [1:0]  notch_span_sel_i,
   input  wire logic [1:0]  attenuation_level_i,
   // Oscillator pins.
   input  wire logic        osc_in_pin_i,
   output logic             osc_out_pin_o,
   output logic             osc_out_pin_oe_o,
   // Filter clock pin.
   input  wire logic        filt_clk_pin_i,
   output logic             filt_clk_pin_o,
   output logic             filt_clk_pin_oe_o,
   // Clock source status.
   output logic             osc_enable_o,
   output logic             ttl_thresh_o,
   output logic             code_invalid_o,
   // Filter data path.
   input  wire logic [11:0] filter_in_i,
   output logic [11:0]      filter_sample_o,
   output logic [11:0]      bandpass_o,
   output logic             sample_strobe_o,
   // Decoded configuration.
   output logic [9:0]       divide_factor_o,
   output logic [13:0]      ratio_x100_o,
   output logic [9:0]       width_permille_o,
   output logic [5:0]       depth_db_o,
   output logic [4:0]       config_index_o,
   output logic [15:0]      filt_clk_period_o
);

   // Programming codes, held in flip-flops.
   logic [1:0] div_sel_q;
   logic [1:0] src_sel_q;
   logic [1:0] ratio_sel_q;
   logic [1:0] span_sel_q;
   logic [1:0] atten_sel_q;
   logic [1:0] div_sel_d;
   logic [1:0] src_sel_d;
   logic [1:0] ratio_sel_d;
   logic [1:0] span_sel_d;
   logic [1:0] atten_sel_d;
   logic       invalid_d;
   logic       invalid_q;

   // Maps the unused fourth code to ground.
   function automatic logic [1:0] fold_code(input logic [1:0] code);
      fold_code = (code == notch_cfg_pkg::LVL_INVALID) ? notch_cfg_pkg::LVL_GND : code;
   endfunction : fold_code

   function automatic logic [4:0] level_index(input logic [1:0] code);
      case (code)
         notch_cfg_pkg::LVL_POS: level_index = notch_cfg_pkg::IDX_POS;
         notch_cfg_pkg::LVL_NEG: level_index = notch_cfg_pkg::IDX_NEG;
         default:                level_index = notch_cfg_pkg::IDX_GND;
      endcase
   endfunction : level_index

   always_comb begin
      div_sel_d   = fold_code(divide_factor_sel_i);
      src_sel_d   = fold_code(clock_source_sel_i);
      ratio_sel_d = fold_code(sample_to_notch_pick_i);
      span_sel_d  = fold_code(notch_span_sel_i);
      // Two-level input: only the negative rail differs from ground.
      atten_sel_d = (attenuation_level_i == notch_cfg_pkg::LVL_NEG) ? notch_cfg_pkg::LVL_NEG
                                                                     : notch_cfg_pkg::LVL_GND;
      invalid_d   = (divide_factor_sel_i == notch_cfg_pkg::LVL_INVALID)
                  | (clock_source_sel_i == notch_cfg_pkg::LVL_INVALID)
                  | (sample_to_notch_pick_i == notch_cfg_pkg::LVL_INVALID)
                  | (notch_span_sel_i == notch_cfg_pkg::LVL_INVALID)
                  | (attenuation_level_i == notch_cfg_pkg::LVL_INVALID)
                  | (attenuation_level_i == notch_cfg_pkg::LVL_POS);
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         div_sel_q   <= notch_cfg_pkg::LVL_GND;
         src_sel_q   <= notch_cfg_pkg::LVL_GND;
         ratio_sel_q <= notch_cfg_pkg::LVL_GND;
         span_sel_q  <= notch_cfg_pkg::LVL_GND;
         atten_sel_q <= notch_cfg_pkg::LVL_GND;
         invalid_q   <= 1'b0;
      end else begin
         div_sel_q   <= div_sel_d;
         src_sel_q   <= src_sel_d;
         ratio_sel_q <= ratio_sel_d;
         span_sel_q  <= span_sel_d;
         atten_sel_q <= atten_sel_d;
         invalid_q   <= invalid_d;
      end
   end

   // Clock source mode.
   notch_cfg_pkg::clk_src_t mode_q;
   notch_cfg_pkg::clk_src_t mode_d;

   always_comb begin
      case (src_sel_q)
         notch_cfg_pkg::LVL_POS: mode_d = notch_cfg_pkg::SRC_OSC;
         notch_cfg_pkg::LVL_NEG: mode_d = notch_cfg_pkg::SRC_TTL;
         default:                mode_d = notch_cfg_pkg::SRC_CMOS;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         mode_q <= notch_cfg_pkg::SRC_CMOS;
      end else begin
         mode_q <= mode_d;
      end
   end

   logic osc_on;
   logic ttl_on;

   always_comb begin
      osc_on = 1'b0;
      ttl_on = 1'b0;
      case (mode_q)
         notch_cfg_pkg::SRC_OSC:  osc_on = 1'b1;
         notch_cfg_pkg::SRC_CMOS: osc_on = 1'b0;
         notch_cfg_pkg::SRC_TTL:  ttl_on = 1'b1;
         default:                 osc_on = 1'b0;
      endcase
   end

   // Oscillator input edge detection and inverting drive of the output pin.
   logic osc_prev_q;
   logic osc_prev_d;
   logic osc_drv_q;
   logic osc_drv_d;
   logic osc_rise;

   always_comb begin
      osc_prev_d = osc_on ? osc_in_pin_i : 1'b0;
      osc_drv_d  = osc_on ? ~osc_in_pin_i : 1'b0;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         osc_prev_q <= 1'b0;
         osc_drv_q  <= 1'b0;
      end else begin
         osc_prev_q <= osc_prev_d;
         osc_drv_q  <= osc_drv_d;
      end
   end

   assign osc_rise = osc_on & osc_in_pin_i & ~osc_prev_q;

   // Half period of the selected division factor.
   logic [9:0] half_count;
   logic [9:0] factor_d;

   always_comb begin
      case (div_sel_q)
         notch_cfg_pkg::LVL_POS: begin
            half_count = notch_cfg_pkg::HALF_POS;
            factor_d   = notch_cfg_pkg::DIV_POS;
         end
         notch_cfg_pkg::LVL_NEG: begin
            half_count = notch_cfg_pkg::HALF_NEG;
            factor_d   = notch_cfg_pkg::DIV_NEG;
         end
         default: begin
            half_count = notch_cfg_pkg::HALF_GND;
            factor_d   = notch_cfg_pkg::DIV_GND;
         end
      endcase
   end

   logic div_clk;

   osc_divider u_divider (
      .clock_i      (clock_i),
      .reset_i      (reset_i),
      .enable_i     (osc_on),
      .src_rise_i   (osc_rise),
      .half_count_i (half_count),
      .div_clk_o    (div_clk)
   );

   // Filter clock: the divider output in oscillator mode, otherwise the pin.
   logic filt_clk;
   logic filt_prev_q;
   logic filt_prev_d;
   logic filt_rise;

   assign filt_clk    = osc_on ? div_clk : filt_clk_pin_i;
   assign filt_prev_d = filt_clk;
   assign filt_rise   = filt_clk & ~filt_prev_q;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         filt_prev_q <= 1'b0;
      end else begin
         filt_prev_q <= filt_prev_d;
      end
   end

   filter_sampler u_sampler (
      .clock_i     (clock_i),
      .reset_i     (reset_i),
      .filt_rise_i (filt_rise),
      .sample_in_i (filter_in_i),
      .sample_o    (filter_sample_o),
      .bandpass_o  (bandpass_o),
      .strobe_o    (sample_strobe_o)
   );

   // Period of the filter clock, in system clock cycles, saturating.
   logic [15:0] period_cnt_q;
   logic [15:0] period_cnt_d;
   logic [15:0] period_q;
   logic [15:0] period_d;

   always_comb begin
      period_cnt_d = period_cnt_q;
      period_d     = period_q;
      if (filt_rise) begin
         period_d     = period_cnt_q;
         period_cnt_d = 16'h0001;
      end else if (period_cnt_q != notch_cfg_pkg::PERIOD_MAX) begin
         period_cnt_d = period_cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         period_cnt_q <= notch_cfg_pkg::PERIOD_ZERO;
         period_q     <= notch_cfg_pkg::PERIOD_ZERO;
      end else begin
         period_cnt_q <= period_cnt_d;
         period_q     <= period_d;
      end
   end

   // Decoded filter settings, each from its own input alone; the configuration index from the ratio, depth and width inputs together.
   logic [13:0] ratio_d;
   logic [9:0]  width_d;
   logic [5:0]  depth_d;
   logic [4:0]  index_d;
   logic [13:0] ratio_q;
   logic [9:0]  width_q;
   logic [5:0]  depth_q;
   logic [4:0]  index_q;
   logic [9:0]  factor_q;

   always_comb begin
      case (ratio_sel_q)
         notch_cfg_pkg::LVL_POS: ratio_d = notch_cfg_pkg::RATIO_POS;
         notch_cfg_pkg::LVL_NEG: ratio_d = notch_cfg_pkg::RATIO_NEG;
         default:                ratio_d = notch_cfg_pkg::RATIO_GND;
      endcase
      case (span_sel_q)
         notch_cfg_pkg::LVL_POS: width_d = notch_cfg_pkg::WIDTH_POS;
         notch_cfg_pkg::LVL_NEG: width_d = notch_cfg_pkg::WIDTH_NEG;
         default:                width_d = notch_cfg_pkg::WIDTH_GND;
      endcase
      depth_d = (atten_sel_q == notch_cfg_pkg::LVL_NEG) ? notch_cfg_pkg::DEPTH_NEG
                                                       : notch_cfg_pkg::DEPTH_GND;
      index_d = 5'(level_index(ratio_sel_q) * notch_cfg_pkg::WEIGHT_RATIO)
              + 5'(level_index(atten_sel_q) * notch_cfg_pkg::WEIGHT_DEPTH)
              + level_index(span_sel_q);
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         ratio_q  <= notch_cfg_pkg::RATIO_GND;
         width_q  <= notch_cfg_pkg::WIDTH_GND;
         depth_q  <= notch_cfg_pkg::DEPTH_GND;
         index_q  <= 5'h00;
         factor_q <= notch_cfg_pkg::DIV_GND;
      end else begin
         ratio_q  <= ratio_d;
         width_q  <= width_d;
         depth_q  <= depth_d;
         index_q  <= index_d;
         factor_q <= factor_d;
      end
   end

   // Pin drive: the filter clock pin is driven only in oscillator mode.
   // The oscillator output pin floats when the oscillator is off.
   assign filt_clk_pin_o    = osc_on ? div_clk : 1'b0;
   assign filt_clk_pin_oe_o = osc_on;
   assign osc_out_pin_o     = osc_drv_q;
   assign osc_out_pin_oe_o  = osc_on;
   assign osc_enable_o      = osc_on;
   assign ttl_thresh_o      = ttl_on;
   assign code_invalid_o    = invalid_q;
   assign divide_factor_o   = factor_q;
   assign ratio_x100_o      = ratio_q;
   assign width_permille_o  = width_q;
   assign depth_db_o        = depth_q;
   assign config_index_o    = index_q;
   assign filt_clk_period_o = period_q;

endmodule : notch_filter_clock_config

// ---- verification/notch_cfg_monitor.sv ----
// Checker of the notch filter clock and configuration ports.
`timescale 1ns/1ps
module notch_cfg_monitor (
   // Clock and reset.
   input wire logic        clock_i,
   input wire logic        reset_i,
   // Programming inputs.
   input wire logic [1:0]  divide_factor_sel_i,
   input wire logic [1:0]  clock_source_sel_i,
   input wire logic [1:0]  sample_to_notch_pick_i,
   input wire logic [1:0]  notch_span_sel_i,
   input wire logic [1:0]  attenuation_level_i,
   // Pins and status.
   input wire logic        osc_in_pin_i,
   input wire logic        osc_out_pin_o,
   input wire logic        osc_out_pin_oe_o,
   input wire logic        filt_clk_pin_o,
   input wire logic        filt_clk_pin_oe_o,
   input wire logic        osc_enable_o,
   input wire logic        ttl_thresh_o,
   input wire logic        code_invalid_o,
   // Data path and divider factor.
   input wire logic [11:0] filter_sample_o,
   input wire logic [11:0] bandpass_o,
   input wire logic        sample_strobe_o,
   input wire logic [9:0]  divide_factor_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   AST_OE_MATCH: assert property (filt_clk_pin_oe_o == osc_enable_o && osc_out_pin_oe_o == osc_enable_o)
      else $error("Pin enables disagree with oscillator mode.");
   AST_OE_SRC: assert property ($stable(clock_source_sel_i)[*3] |-> filt_clk_pin_oe_o == (clock_source_sel_i == 2'h1))
      else $error("Filter clock pin direction does not follow the source code.");
   AST_OSC_DRIVE: assert property ($past(osc_enable_o) |-> osc_out_pin_o == !$past(osc_in_pin_i))
      else $error("Oscillator output pin is not the inverted oscillator input.");
   AST_TTL_EXCL: assert property (ttl_thresh_o |-> !osc_enable_o)
      else $error("TTL input mode while oscillator runs.");
   AST_MODE_TTL: assert property ((clock_source_sel_i == 2'h2)[*4] |-> ttl_thresh_o && !osc_enable_o)
      else $error("Negative rail source code did not select TTL input.");
   AST_MODE_OSC: assert property ((clock_source_sel_i == 2'h1)[*4] |-> osc_enable_o && !ttl_thresh_o)
      else $error("Positive rail source code did not start the oscillator.");
   AST_PIN_IDLE: assert property ((!osc_enable_o)[*3] |-> !filt_clk_pin_o && !osc_out_pin_o)
      else $error("Pins driven while oscillator is off.");
   AST_DIV_FACTOR: assert property ($stable(divide_factor_sel_i)[*4] |-> divide_factor_o ==
      (divide_factor_sel_i == 2'h1 ? 10'h2CC : (divide_factor_sel_i == 2'h2 ? 10'h002 : 10'h254)))
      else $error("Divider factor does not match its select code.");
   AST_INVALID: assert property ($stable({divide_factor_sel_i, clock_source_sel_i, sample_to_notch_pick_i,
      notch_span_sel_i, attenuation_level_i})[*3] |-> code_invalid_o == (divide_factor_sel_i == 2'h3 ||
      clock_source_sel_i == 2'h3 || sample_to_notch_pick_i == 2'h3 || notch_span_sel_i == 2'h3 ||
      attenuation_level_i[0]))
      else $error("Invalid code flag wrong.");
   AST_STROBE_PULSE: assert property (sample_strobe_o |=> !sample_strobe_o)
      else $error("Sample strobe longer than one cycle.");
   AST_DATA_HOLD: assert property (!sample_strobe_o && !$past(reset_i) |-> $stable(filter_sample_o) &&
      $stable(bandpass_o))
      else $error("Sample data changed without a strobe.");
   AST_BP_CHAIN: assert property (sample_strobe_o && !$past(reset_i) |-> bandpass_o == $past(filter_sample_o))
      else $error("Bandpass output is not the previous sample.");
endmodule : notch_cfg_monitor

bind notch_filter_clock_config notch_cfg_monitor u_notch_cfg_monitor (
   .clock_i(clock_i), .reset_i(reset_i), .divide_factor_sel_i(divide_factor_sel_i),
   .clock_source_sel_i(clock_source_sel_i), .sample_to_notch_pick_i(sample_to_notch_pick_i),
   .notch_span_sel_i(notch_span_sel_i), .attenuation_level_i(attenuation_level_i), .osc_in_pin_i(osc_in_pin_i),
   .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_o(osc_out_pin_oe_o), .filt_clk_pin_o(filt_clk_pin_o),
   .filt_clk_pin_oe_o(filt_clk_pin_oe_o), .osc_enable_o(osc_enable_o), .ttl_thresh_o(ttl_thresh_o),
   .code_invalid_o(code_invalid_o), .filter_sample_o(filter_sample_o), .bandpass_o(bandpass_o),
   .sample_strobe_o(sample_strobe_o), .divide_factor_o(divide_factor_o)
);

// ---- verification/osc_crystal_model.sv ----
// Behavioural crystal that swings the oscillator input pin.
`timescale 1ns/1ps
module osc_crystal_model #(
   parameter int HALF_CYCLES = 2
) (
   // Clock.
   input  wire logic clock_i,
   // Crystal fitted and amplifier output enabled.
   input  wire logic run_i,
   input  wire logic osc_out_oe_i,
   // Oscillator input pin.
   output logic      osc_in_o
);
   int count;

   // The crystal swings only while the amplifier drives it; nothing else loads the output pin.
   initial begin
      osc_in_o = 1'b0;
      count = 0;
      forever begin
         @(posedge clock_i);
         #1;
         if (run_i && osc_out_oe_i) begin
            count++;
            if (count >= HALF_CYCLES) begin
               count = 0;
               osc_in_o = ~osc_in_o;
            end
         end else begin
            count = 0;
            osc_in_o = 1'b0;
         end
      end
   end
endmodule : osc_crystal_model

// ---- verification/tb_top.sv ----
// Self-checking testbench of the notch filter clock and configuration block.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
   localparam int OSC_HALF = 2;
   logic        clock_i, reset_i, osc_in, ext_clk, filt_wire, osc_out, osc_oe, filt_out, filt_oe;
   logic        osc_en, ttl, invalid, strobe, track;
   logic [1:0]  div_sel, src_sel, ratio_sel, span_sel, att_sel;
   logic [11:0] filter_in, sample, bandpass, prev;
   logic [9:0]  div_o, width_o;
   logic [13:0] ratio_o;
   logic [5:0]  depth_o;
   logic [4:0]  index_o;
   logic [15:0] period_o;
   logic [23:0] exp_q[$];
   logic [23:0] exp_v;
   logic [31:0] seen;
   int          bad_count, n_checks, last_len, hc, lc;
   int          seed = 32'h0000_a00e;
   logic [1:0]  lv[3] = '{2'h1, 2'h0, 2'h2};
   int          div_n[3] = '{716, 596, 2};
   logic [9:0]  e_div[4] = '{10'h254, 10'h2CC, 10'h002, 10'h254};
   logic [13:0] e_ratio[4] = '{14'h1388, 14'h0D05, 14'h2710, 14'h1388};
   logic [9:0]  e_width[4] = '{10'h104, 10'h226, 10'h07F, 10'h104};

   assign filt_wire = filt_oe ? filt_out : ext_clk;

   notch_filter_clock_config dut (
      .clock_i(clock_i), .reset_i(reset_i), .divide_factor_sel_i(div_sel), .clock_source_sel_i(src_sel),
      .sample_to_notch_pick_i(ratio_sel), .notch_span_sel_i(span_sel), .attenuation_level_i(att_sel),
      .osc_in_pin_i(osc_in), .osc_out_pin_o(osc_out), .osc_out_pin_oe_o(osc_oe), .filt_clk_pin_i(filt_wire),
      .filt_clk_pin_o(filt_out), .filt_clk_pin_oe_o(filt_oe), .osc_enable_o(osc_en), .ttl_thresh_o(ttl),
      .code_invalid_o(invalid), .filter_in_i(filter_in), .filter_sample_o(sample), .bandpass_o(bandpass),
      .sample_strobe_o(strobe), .divide_factor_o(div_o), .ratio_x100_o(ratio_o), .width_permille_o(width_o),
      .depth_db_o(depth_o), .config_index_o(index_o), .filt_clk_period_o(period_o)
   );

   osc_crystal_model #(.HALF_CYCLES(OSC_HALF)) u_xtal (
      .clock_i(clock_i), .run_i(1'b1), .osc_out_oe_i(osc_oe), .osc_in_o(osc_in)
   );

   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end

   task step(input int n);
      repeat (n) begin
         @(posedge clock_i);
         #1;
      end
   endtask : step

   task end_sim;
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim

   task set_cfg(input logic [1:0] d, s, r, w, a);
      div_sel = d;
      src_sel = s;
      ratio_sel = r;
      span_sel = w;
      att_sel = a;
      step(4);
   endtask : set_cfg

   // Counts the cycles that the divided clock stays at one level.
   task run_lvl(input logic v, output int c);
      c = 0;
      while (filt_out === v && c < 4000) begin
         step(1);
         c++;
      end
   endtask : run_lvl

   // One pin clock cycle carrying a fresh sample; the expected outputs are queued at the rise.
   task pulse(input int hi, input int lo);
      filter_in = 12'($random(seed));
      ext_clk = 1'b1;
      exp_q.push_back({filter_in, prev});
      prev = filter_in;
      step(hi);
      ext_clk = 1'b0;
      step(lo);
      last_len = hi + lo;
   endtask : pulse

   always @(posedge clock_i) begin
      if (track && strobe === 1'b1) begin
         if (exp_q.size() == 0) begin
            `CHK(strobe, 1'b0)
         end else begin
            // The macro evaluates its arguments twice, so the note is taken off the queue once here.
            exp_v = exp_q.pop_front();
            `CHK({sample, bandpass}, exp_v)
         end
      end
   end

   initial begin
      #(40 * 60000);
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end_sim;
   end

   initial begin
      reset_i = 1'b1;
      {div_sel, src_sel, ratio_sel, span_sel, att_sel} = 10'h000;
      {ext_clk, track} = 2'b00;
      {filter_in, prev} = 24'h00_0000;
      step(2);
      reset_i = 1'b0;
      step(1);
      `CHK({filt_oe, osc_en, div_o, ratio_o}, {2'b00, 10'h254, 14'h1388})
      `CHK({width_o, depth_o, period_o}, {10'h104, 6'h1E, 16'h0000})
      for (int c = 0; c < 4; c++) begin
         set_cfg(2'(c), 2'(c), 2'(c), 2'(c), 2'(c));
         `CHK(div_o, e_div[c])
         `CHK(ratio_o, e_ratio[c])
         `CHK(width_o, e_width[c])
         `CHK(depth_o, (c == 2) ? 6'h28 : 6'h1E)
         `CHK(invalid, 1'(c == 1 || c == 3))
         `CHK({osc_en, filt_oe, ttl}, {1'(c == 1), 1'(c == 1), 1'(c == 2)})
      end
      seen = 32'h0000_0000;
      for (int r = 0; r < 3; r++) begin
         for (int w = 0; w < 3; w++) begin
            for (int a = 0; a < 2; a++) begin
               set_cfg(2'h0, 2'h0, lv[r], lv[w], a ? 2'h2 : 2'h0);
               `CHK(seen[index_o], 1'b0)
               `CHK(depth_o, a ? 6'h28 : 6'h1E)
               `CHK(ratio_o, e_ratio[lv[r]])
               `CHK(width_o, e_width[lv[w]])
               seen[index_o] = 1'b1;
            end
         end
      end
      for (int i = 0; i < 3; i++) begin
         set_cfg(lv[i], 2'h1, 2'h0, 2'h0, 2'h0);
         run_lvl(1'b1, hc);
         run_lvl(1'b0, hc);
         run_lvl(1'b1, hc);
         run_lvl(1'b0, lc);
         step(3);
         `CHK(hc, div_n[i] * OSC_HALF)
         `CHK(lc, div_n[i] * OSC_HALF)
         `CHK(period_o, 16'(div_n[i] * 2 * OSC_HALF))
      end
      src_sel = 2'h0;
      reset_i = 1'b1;
      step(2);
      reset_i = 1'b0;
      prev = 12'h000;
      foreach (lv[k]) begin
         if (k > 0) begin
            set_cfg(2'h0, lv[k], 2'h0, 2'h0, 2'h0);
            `CHK(ttl, 1'(lv[k] == 2'h2))
            track = 1'b1;
            repeat (20) pulse(1 + ($unsigned($random(seed)) % 3), 1 + ($unsigned($random(seed)) % 3));
            hc = last_len;
            pulse(1, 3);
            `CHK(period_o, 16'(hc))
            step(4);
            `CHK(exp_q.size(), 0)
            track = 1'b0;
         end
      end
      end_sim;
   end
endmodule : tb_top
